// file: include/hbsef_cfg.svh
`ifndef HBSEF_CFG_SVH
`define HBSEF_CFG_SVH
// register offsets on the plain port (byte addresses)
`define HBSEF_ADDR_COMMAND   8'h04
`define HBSEF_ADDR_STATUS    8'h06
`define HBSEF_ADDR_ERROR_COMMAND    8'h08
`define HBSEF_ADDR_MASK      8'h0C
`define HBSEF_ADDR_IRQSTS    8'h0E
// status field positions
`define HBSEF_BIT_PARITY     15
`define HBSEF_BIT_SYSERR     14
`define HBSEF_BIT_UNSUPP     13
`define HBSEF_BIT_CABORT     12
`define HBSEF_BIT_TABORT     11
`define HBSEF_SEL_HI         10
`define HBSEF_SEL_LO         9
// command register system-error enable bit
`define HBSEF_BIT_CMD_SERR   8
// error command enables
`define HBSEF_BIT_EC_UNSUPP  1
`define HBSEF_BIT_EC_CABORT  0
// reset / fixed values
`define HBSEF_SEL_FAST       2'h0
`define HBSEF_ZERO16         16'h0000
// lower status bits, read-only constant outside this block
`define HBSEF_STATUS_LOW     9'h090
`endif

// file: include/hbsef_pkg.sv
package hbsef_pkg;
   // sticky error flags, one per status event
   typedef struct packed
   {
      logic syserr;
      logic unsupp;
      logic cabort;
   } hbsef_flags_t;
endpackage : hbsef_pkg

// file: hdl/hbsef_flag.sv
`timescale 1ns/10ps
// one sticky write-one-to-clear flag; set wins over clear
module hbsef_flag
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic set,
   input  wire logic clear,
   output logic      flag
);
   typedef struct packed { logic f; } hbsef_fst_t;
   hbsef_fst_t state;
   hbsef_fst_t next_state;

   // hold until cleared; a simultaneous set is kept
   always_comb
   begin
      next_state = state;
      if (clear)
         next_state.f = 1'b0;
      if (set)
         next_state.f = 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         state <= '0;
      else
         state <= next_state;
   end

   assign flag = state.f;

   AST_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n) set |=> flag)
      else $error("flag lost a set event");
   AST_CLEAR_ONLY: assert property (@(posedge clk) disable iff (!reset_n) (clear && !set) |=> !flag)
      else $error("flag did not clear");
endmodule : hbsef_flag

// file: hdl/hbsef_gate.sv
`timescale 1ns/10ps
// decides if an error may raise a system error message
module hbsef_gate
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic err,
   input  wire logic cmd_en,
   input  wire logic ec_en,
   output logic      send
);
   typedef struct packed { logic s; } hbsef_gst_t;
   hbsef_gst_t state;
   hbsef_gst_t next_state;

   // both enables needed; registered so the message is a clean pulse
   always_comb
   begin
      next_state   = state;
      next_state.s = err & cmd_en & ec_en;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         state <= '0;
      else
         state <= next_state;
   end

   assign send = state.s;

   AST_BOTH_ENABLES: assert property (@(posedge clk) disable iff (!reset_n)
      send |-> $past(err) && $past(cmd_en) && $past(ec_en))
      else $error("system error raised without both enables");
endmodule : hbsef_gate

// file: hdl/hbsef_top.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "hbsef_cfg.svh"
// Function
// - parity-error-detected bit 15 always reads zero; writes ignored.
// - system-error-signalled bit 14 sets when a system error message is sent.
// - system error raised only if command and error command enables both set.
// - unsupported-request completion sets bit 13.
// - completer-abort completion sets bit 12.
// - bits 14..12 clear on written one unless their own event comes in the same cycle, stay set otherwise.
// - target-abort-signalled bit 11 always reads zero.
// - select-timing bits 10:9 read fast decode 00; writes ignored.
// - hardwired status bits ignore writes and never change.
module hbsef_top
   import hbsef_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]      rdata,
   input  wire logic        cpl_unsupp,
   input  wire logic        cpl_cabort,
   output logic             serr_msg,
   output logic             irq
);
   typedef struct packed
   {
      logic [15:0] command;
      logic [15:0] error_command;
      logic [2:0]  mask;
      logic [2:0]  irqsts;
      logic [15:0] rdata;
   } hbsef_state_t;

   hbsef_state_t state;
   hbsef_state_t next_state;
   hbsef_flags_t flags;
   logic         send_unsupp;
   logic         send_cabort;
   logic         serr_send;
   logic         wr_status;
   logic [15:0]  status_word;
   logic [2:0]   events;

   assign wr_status = wr && (addr == `HBSEF_ADDR_STATUS);

   // error-to-message gating, one per function 0 error source
   hbsef_gate u_gate_unsupp
   (
      .clk     (clk),
      .reset_n (reset_n),
      .err     (cpl_unsupp),
      .cmd_en  (state.command[`HBSEF_BIT_CMD_SERR]),
      .ec_en   (state.error_command[`HBSEF_BIT_EC_UNSUPP]),
      .send    (send_unsupp)
   );
   hbsef_gate u_gate_cabort
   (
      .clk     (clk),
      .reset_n (reset_n),
      .err     (cpl_cabort),
      .cmd_en  (state.command[`HBSEF_BIT_CMD_SERR]),
      .ec_en   (state.error_command[`HBSEF_BIT_EC_CABORT]),
      .send    (send_cabort)
   );

   assign serr_send = send_unsupp | send_cabort;
   assign serr_msg  = serr_send;

   // sticky write-one-to-clear flags
   hbsef_flag u_flag_syserr
   (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (serr_send),
      .clear   (wr_status && wdata[`HBSEF_BIT_SYSERR]),
      .flag    (flags.syserr)
   );
   hbsef_flag u_flag_unsupp
   (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (cpl_unsupp),
      .clear   (wr_status && wdata[`HBSEF_BIT_UNSUPP]),
      .flag    (flags.unsupp)
   );
   hbsef_flag u_flag_cabort
   (
      .clk     (clk),
      .reset_n (reset_n),
      .set     (cpl_cabort),
      .clear   (wr_status && wdata[`HBSEF_BIT_CABORT]),
      .flag    (flags.cabort)
   );

   // status image; hardwired fields are constants so writes cannot reach them
   always_comb
   begin
      status_word                                   = `HBSEF_ZERO16;
      status_word[`HBSEF_SEL_LO-1:0]                = `HBSEF_STATUS_LOW;
      status_word[`HBSEF_BIT_PARITY]                = 1'b0;
      status_word[`HBSEF_BIT_SYSERR]                = flags.syserr;
      status_word[`HBSEF_BIT_UNSUPP]                = flags.unsupp;
      status_word[`HBSEF_BIT_CABORT]                = flags.cabort;
      status_word[`HBSEF_BIT_TABORT]                = 1'b0;
      status_word[`HBSEF_SEL_HI:`HBSEF_SEL_LO]      = `HBSEF_SEL_FAST;
   end

   assign events = {serr_send, cpl_unsupp, cpl_cabort};

   // register writes, interrupt status and one-cycle-late read data
   always_comb
   begin
      next_state       = state;
      next_state.rdata = `HBSEF_ZERO16;
      if (wr)
      begin
         unique case (addr)
            `HBSEF_ADDR_COMMAND: next_state.command = wdata;
            `HBSEF_ADDR_ERROR_COMMAND:  next_state.error_command  = wdata;
            `HBSEF_ADDR_MASK:    next_state.mask    = wdata[2:0];
            default:             ;
         endcase
      end
      if (rd)
      begin
         unique case (addr)
            `HBSEF_ADDR_COMMAND: next_state.rdata = state.command;
            `HBSEF_ADDR_STATUS:  next_state.rdata = status_word;
            `HBSEF_ADDR_ERROR_COMMAND:  next_state.rdata = state.error_command;
            `HBSEF_ADDR_MASK:    next_state.rdata = {13'h0000, state.mask};
            `HBSEF_ADDR_IRQSTS:  next_state.rdata = {13'h0000, state.irqsts};
            default:             next_state.rdata = `HBSEF_ZERO16;
         endcase
      end
      // read clears interrupt status, but new events win
      if (rd && (addr == `HBSEF_ADDR_IRQSTS))
         next_state.irqsts = 3'h0;
      next_state.irqsts = next_state.irqsts | events;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         state <= '0;
      else
         state <= next_state;
   end

   assign rdata = state.rdata;
   assign irq   = |(state.irqsts & state.mask);

   AST_PARITY_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
      $past(rd) && ($past(addr) == `HBSEF_ADDR_STATUS) |-> !rdata[`HBSEF_BIT_PARITY])
      else $error("parity bit read as one");
   AST_SERR_SETS: assert property (@(posedge clk) disable iff (!reset_n)
      serr_msg |=> flags.syserr)
      else $error("system error flag not set after message");
   AST_NO_SERR_DISABLED: assert property (@(posedge clk) disable iff (!reset_n)
      !state.command[`HBSEF_BIT_CMD_SERR] ##1 !state.command[`HBSEF_BIT_CMD_SERR] |-> !serr_msg)
      else $error("system error with command enable off");
   AST_UNSUPP_SETS: assert property (@(posedge clk) disable iff (!reset_n)
      cpl_unsupp |=> flags.unsupp)
      else $error("unsupported flag not set");
   AST_CABORT_SETS: assert property (@(posedge clk) disable iff (!reset_n)
      cpl_cabort |=> flags.cabort)
      else $error("completer abort flag not set");
   AST_W1C_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
      flags.unsupp && !(wr_status && wdata[`HBSEF_BIT_UNSUPP]) |=> flags.unsupp)
      else $error("flag dropped without a one written");
   AST_TABORT_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
      status_word[`HBSEF_BIT_TABORT] == 1'b0)
      else $error("target abort bit not zero");
   AST_SEL_FAST: assert property (@(posedge clk) disable iff (!reset_n)
      $past(rd) && ($past(addr) == `HBSEF_ADDR_STATUS) |-> rdata[`HBSEF_SEL_HI:`HBSEF_SEL_LO] == 2'h0)
      else $error("select timing not fast");
   AST_HARDWIRED: assert property (@(posedge clk) disable iff (!reset_n)
      wr_status |=> status_word[`HBSEF_SEL_LO-1:0] == `HBSEF_STATUS_LOW)
      else $error("hardwired bits changed");
   AST_SET_BEATS_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
      cpl_cabort && wr_status && wdata[`HBSEF_BIT_CABORT] |=> flags.cabort)
      else $error("clear beat simultaneous set");

   // write-one-to-clear keeps the other two flags as well
   AST_W1C_KEEP_SYSERR: assert property (@(posedge clk) disable iff (!reset_n)
      flags.syserr && !(wr_status && wdata[`HBSEF_BIT_SYSERR])
      |=> flags.syserr)
      else $error("system error flag dropped without a one written");

   AST_W1C_KEEP_CABORT: assert property (@(posedge clk) disable iff (!reset_n)
      flags.cabort && !(wr_status && wdata[`HBSEF_BIT_CABORT])
      |=> flags.cabort)
      else $error("abort flag dropped without a one written");

   // a written one clears when no event competes in that cycle
   AST_W1C_CLEAR_SYSERR: assert property (@(posedge clk) disable iff (!reset_n)
      wr_status && wdata[`HBSEF_BIT_SYSERR] && !serr_send
      |=> !flags.syserr)
      else $error("system error flag not cleared by a one");

   AST_W1C_CLEAR_UNSUPP: assert property (@(posedge clk) disable iff (!reset_n)
      wr_status && wdata[`HBSEF_BIT_UNSUPP] && !cpl_unsupp
      |=> !flags.unsupp)
      else $error("unsupported flag not cleared by a one");

   AST_W1C_CLEAR_CABORT: assert property (@(posedge clk) disable iff (!reset_n)
      wr_status && wdata[`HBSEF_BIT_CABORT] && !cpl_cabort
      |=> !flags.cabort)
      else $error("abort flag not cleared by a one");

   // flags rise only for their own cause; a stray set would hide real errors
   AST_SYSERR_ONLY_MSG: assert property (@(posedge clk) disable iff (!reset_n)
      !flags.syserr && !serr_send
      |=> !flags.syserr)
      else $error("system error flag set without a message");

   AST_UNSUPP_ONLY_EVENT: assert property (@(posedge clk) disable iff (!reset_n)
      !flags.unsupp && !cpl_unsupp
      |=> !flags.unsupp)
      else $error("unsupported flag set without a completion");

   AST_CABORT_ONLY_EVENT: assert property (@(posedge clk) disable iff (!reset_n)
      !flags.cabort && !cpl_cabort
      |=> !flags.cabort)
      else $error("abort flag set without a completion");

   // message needs a cause one cycle before it
   AST_SERR_HAS_CAUSE: assert property (@(posedge clk) disable iff (!reset_n)
      serr_msg
      |-> $past(cpl_unsupp) || $past(cpl_cabort))
      else $error("system error message without an error");

   // enabled errors must not be swallowed
   AST_SERR_UNSUPP_EN: assert property (@(posedge clk) disable iff (!reset_n)
      cpl_unsupp && state.command[`HBSEF_BIT_CMD_SERR] && state.error_command[`HBSEF_BIT_EC_UNSUPP]
      |=> serr_msg)
      else $error("enabled unsupported error sent no message");

   AST_SERR_CABORT_EN: assert property (@(posedge clk) disable iff (!reset_n)
      cpl_cabort && state.command[`HBSEF_BIT_CMD_SERR] && state.error_command[`HBSEF_BIT_EC_CABORT]
      |=> serr_msg)
      else $error("enabled abort error sent no message");

   // the per-source enable alone must gate its error
   AST_NO_SERR_EC_UNSUPP: assert property (@(posedge clk) disable iff (!reset_n)
      cpl_unsupp && !cpl_cabort && !state.error_command[`HBSEF_BIT_EC_UNSUPP]
      |=> !serr_msg)
      else $error("unsupported error sent with its enable off");

   AST_NO_SERR_EC_CABORT: assert property (@(posedge clk) disable iff (!reset_n)
      cpl_cabort && !cpl_unsupp && !state.error_command[`HBSEF_BIT_EC_CABORT]
      |=> !serr_msg)
      else $error("abort error sent with its enable off");

   // status reads return the live image of the cycle of the strobe
   AST_READ_STATUS: assert property (@(posedge clk) disable iff (!reset_n)
      rd && (addr == `HBSEF_ADDR_STATUS)
      |=> rdata == $past(status_word))
      else $error("status read returned a wrong word");

   AST_PARITY_IMAGE: assert property (@(posedge clk) disable iff (!reset_n)
      wr_status
      |=> status_word[`HBSEF_BIT_PARITY] == 1'b0)
      else $error("parity bit took a write");

   // read data stands one cycle only, so a stale word cannot be mistaken
   AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
      !rd
      |=> rdata == `HBSEF_ZERO16)
      else $error("read data not zero outside a read");

   // interrupt status follows every event, even during a clearing read
   AST_IRQSTS_CABORT: assert property (@(posedge clk) disable iff (!reset_n)
      cpl_cabort
      |=> state.irqsts[0])
      else $error("abort event missing in interrupt status");

   AST_IRQSTS_UNSUPP: assert property (@(posedge clk) disable iff (!reset_n)
      cpl_unsupp
      |=> state.irqsts[1])
      else $error("unsupported event missing in interrupt status");

   AST_IRQSTS_SYSERR: assert property (@(posedge clk) disable iff (!reset_n)
      serr_send
      |=> state.irqsts[2])
      else $error("system error event missing in interrupt status");

   // with every source masked the line must never rise
   AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (!reset_n)
      state.mask == 3'h0
      |-> !irq)
      else $error("interrupt raised with every source masked");
endmodule : hbsef_top

// file: test/hbsef_hub_model.sv
`timescale 1ns/10ps
// far-end hub: returns failed completions, counts system error messages
module hbsef_hub_model
(
   input  wire logic clk,
   input  wire logic serr_msg,
   output logic      cpl_unsupp,
   output logic      cpl_cabort,
   output int        serr_cnt
);
   // idle, no completion pending at time zero
   initial
   begin
      cpl_unsupp = 1'b0;
      cpl_cabort = 1'b0;
      serr_cnt   = 0;
   end

   // every high cycle is one message, pulses are one cycle
   always @(posedge clk)
      if (serr_msg === 1'b1)
         serr_cnt++;

   // one completion after lat idle cycles; lat 0 answers promptly
   task automatic complete(input logic unsupp, input int lat);
      @(posedge clk);
      repeat (lat) @(posedge clk);
      cpl_unsupp <= unsupp;
      cpl_cabort <= !unsupp;
      @(posedge clk);
      cpl_unsupp <= 1'b0;
      cpl_cabort <= 1'b0;
   endtask : complete
endmodule : hbsef_hub_model

// file: test/hbsef_top_bench.sv
`timescale 1ns/10ps
`include "hbsef_cfg.svh"
module hbsef_top_bench;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        rd_q = 1'b0;
   logic [15:0] rdata;
   logic        cpl_unsupp;
   logic        cpl_cabort;
   logic        serr_msg;
   logic        irq;
   int          serr_cnt;
   int          errors = 0;
   int          comparisons = 0;
   logic [15:0] exp_q[$];

   // 100 ns period
   always #50 clk = ~clk;

   hbsef_hub_model hub (.clk(clk), .serr_msg(serr_msg), .cpl_unsupp(cpl_unsupp),
                        .cpl_cabort(cpl_cabort), .serr_cnt(serr_cnt));
   hbsef_top dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                  .rdata(rdata), .cpl_unsupp(cpl_unsupp), .cpl_cabort(cpl_cabort),
                  .serr_msg(serr_msg), .irq(irq));

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic results;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   // expected data is queued now, judged by the watcher a cycle later
   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
   endtask : rd_reg

   // read data stands only in the cycle after the strobe
   always @(posedge clk)
      rd_q <= rd;
   always @(negedge clk)
      if (rd_q && exp_q.size() > 0)
         chk(rdata, exp_q.pop_front());

   // hang guard
   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      results;
   end

   initial
   begin
      void'($urandom(18489));
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd_reg(`HBSEF_ADDR_STATUS, 16'h0090);
      rd_reg(8'h20, 16'h0000);
      wr_reg(`HBSEF_ADDR_STATUS, 16'hFFFF);
      rd_reg(`HBSEF_ADDR_STATUS, 16'h0090);
      wr_reg(`HBSEF_ADDR_COMMAND, 16'h0100);
      wr_reg(`HBSEF_ADDR_ERROR_COMMAND, 16'h0003);
      wr_reg(`HBSEF_ADDR_MASK, 16'h0007);
      hub.complete(1'b0, 2);
      repeat (3) @(posedge clk);
      rd_reg(`HBSEF_ADDR_STATUS, 16'h5090);
      @(negedge clk);
      chk({15'h0000, irq}, 16'h0001);
      rd_reg(`HBSEF_ADDR_IRQSTS, 16'h0005);
      rd_reg(`HBSEF_ADDR_IRQSTS, 16'h0000);
      wr_reg(`HBSEF_ADDR_STATUS, 16'h1000);
      rd_reg(`HBSEF_ADDR_STATUS, 16'h4090);
      wr_reg(`HBSEF_ADDR_STATUS, 16'h4000);
      rd_reg(`HBSEF_ADDR_STATUS, 16'h0090);
      @(negedge clk);
      chk({15'h0000, irq}, 16'h0000);
      // only the abort enable left: an unsupported request must stay silent
      wr_reg(`HBSEF_ADDR_ERROR_COMMAND, 16'h0001);
      hub.complete(1'b1, 0);
      repeat (3) @(posedge clk);
      rd_reg(`HBSEF_ADDR_STATUS, 16'h2090);
      chk(16'(serr_cnt), 16'h0001);
      // completion lands on the same edge as the clearing write
      fork
         hub.complete(1'b0, 0);
         wr_reg(`HBSEF_ADDR_STATUS, 16'h3000);
      join
      repeat (3) @(posedge clk);
      rd_reg(`HBSEF_ADDR_STATUS, 16'h5090);
      chk(16'(serr_cnt), 16'h0002);
      wr_reg(`HBSEF_ADDR_STATUS, 16'h7000);
      // random data into the hardwired bits, flags written with zero
      repeat (8)
      begin
         wr_reg(`HBSEF_ADDR_STATUS, 16'($urandom()) & 16'h8FFF);
         rd_reg(`HBSEF_ADDR_STATUS, 16'h0090);
      end
      repeat (2) @(posedge clk);
      results;
   end
endmodule : hbsef_top_bench
